/* design/btc_cfg.svh */
// constants for the timer and counter block
// assumes a 20 MHz controller clock
`ifndef BTC_CFG_SVH
`define BTC_CFG_SVH
`define BTC_CLK_NS 50
`define BTC_TENTHS_NS 100000000
`define BTC_HUND_NS 10000000
`define BTC_MAX8 32'h99999999
`define BTC_MAX4 16'h9999
`define BTC_ZERO8 32'h00000000
`define BTC_ZERO4 16'h0000
`define BTC_DIGIT_MAX 4'h9
`define BTC_DIGIT_MIN 4'h0
`define BTC_DIGIT_ONE 4'h1
`define BTC_CNT_BASE 10'h200
`define BTC_TMR_LAST 8'hFE
`define BTC_SLOT_LAST 3'h7
`define BTC_SLOT_FIRST 3'h0
`define BTC_MEM_DEPTH 1024
`define BTC_ADDR_ONE 10'h001
`endif

/* design/btc_pkg.sv */
// types shared by the timer and counter block
// assumes btc_cfg.svh is on the include path
package btc_pkg;
    typedef struct packed {
        logic en;
        logic rst;
        logic [31:0] preset;
    } btc_tmr_ctl_t;
    typedef struct packed {
        logic count;
        logic rst;
        logic [15:0] preset;
    } btc_cnt_ctl_t;
    typedef struct packed {
        logic up;
        logic down;
        logic rst;
        logic [31:0] preset;
    } btc_udc_ctl_t;
    typedef struct packed {
        logic done;
        logic [31:0] value;
    } btc_stat8_t;
    typedef struct packed {
        logic done;
        logic [15:0] value;
    } btc_stat4_t;
    typedef struct packed {
        logic en;
        logic [9:0] addr;
    } btc_rd_req_t;
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } btc_rd_resp_t;
endpackage

/* design/btc_bcd_step.sv */
// bcd step of one up or down with per-digit carry
// assumes a valid bcd input; saturation is the caller's job
`include "btc_cfg.svh"
module btc_bcd_step #(
    parameter int DIGITS = 8
) (
    input wire logic [4*DIGITS-1:0] value,
    input wire logic up,
    input wire logic down,
    output logic [4*DIGITS-1:0] result
);
    import btc_pkg::*;
    logic [DIGITS:0] carry;
    assign carry[0] = up ^ down;
    genvar i;
    generate
        for (i = 0; i < DIGITS; i++) begin : g_digit
            logic [3:0] dig;
            logic wrap;
            assign dig = value[4*i +: 4];
            assign wrap = up ? (dig == `BTC_DIGIT_MAX)
                             : (dig == `BTC_DIGIT_MIN);
            // decimal carry keeps each digit in 0..9
            assign result[4*i +: 4] = !carry[i] ? dig :
                wrap ? (up ? `BTC_DIGIT_MIN : `BTC_DIGIT_MAX) :
                up ? dig + `BTC_DIGIT_ONE : dig - `BTC_DIGIT_ONE;
            assign carry[i+1] = carry[i] & wrap;
        end
    endgenerate
endmodule

/* design/btc_value_mem.sv */
// value memory: one write port, one read port with registered data
// assumes a synchronous active-high reset on the read register
`include "btc_cfg.svh"
module btc_value_mem (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [9:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic re,
    input wire logic [9:0] raddr,
    output logic [15:0] rdata_ff
);
    logic [15:0] mem [`BTC_MEM_DEPTH];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= `BTC_ZERO4;
        end else if (re) begin
            rdata_ff <= mem[raddr];
        end
    end
endmodule

/* design/btc_top.sv */
// bcd accumulating timers, up, up/down and stage counters
// assumes inputs are synchronous to MCLK and presets are valid bcd
//
// What this block does
// - tenths timer steps 0.1 s, max 9999999.9
// - hundredths timer steps 0.01 s, max 999999.99
// - timer preset and value are 8-digit bcd
// - timer runs only while enabled, holds otherwise
// - timer reset clears value and done flag
// - timer done when value at least preset
// - timer takes two slots, numbers up to 376
// - timer value readable at word of its number
// - up counter counts rising edges only
// - up counter reset forces zero, clears done
// - up counter saturates at 9999 until reset
// - up counter preset and count are 4-digit
// - counter done when count at least preset
// - counter value at word number plus 1000 octal
// - up/down counter has up, down, reset; max 99999999
// - up/down preset and count are 8-digit bcd
// - up/down counter takes two counter slots
// - stage counter cleared only by reset command
`include "btc_cfg.svh"
module btc_top #(
    parameter int TENTHS_CYCLES = `BTC_TENTHS_NS / `BTC_CLK_NS,
    parameter int HUND_CYCLES = `BTC_HUND_NS / `BTC_CLK_NS
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire btc_pkg::btc_tmr_ctl_t TENTHS_CTL,
    input wire logic [7:0] TENTHS_NUM,
    input wire btc_pkg::btc_tmr_ctl_t HUND_CTL,
    input wire logic [7:0] HUND_NUM,
    input wire btc_pkg::btc_cnt_ctl_t UPCNT_CTL,
    input wire logic [7:0] UPCNT_NUM,
    input wire btc_pkg::btc_udc_ctl_t UDC_CTL,
    input wire logic [7:0] UDC_NUM,
    input wire btc_pkg::btc_cnt_ctl_t STAGE_CTL,
    input wire logic [7:0] STAGE_NUM,
    input wire btc_pkg::btc_rd_req_t RD_REQ,
    output btc_pkg::btc_stat8_t TENTHS_STAT,
    output btc_pkg::btc_stat8_t HUND_STAT,
    output btc_pkg::btc_stat4_t UPCNT_STAT,
    output btc_pkg::btc_stat8_t UDC_STAT,
    output btc_pkg::btc_stat4_t STAGE_STAT,
    output btc_pkg::btc_rd_resp_t RD_RESP
);
    import btc_pkg::*;

    // time bases
    logic [31:0] tenths_div_ff;
    logic [31:0] hund_div_ff;
    logic tenths_tick_ff;
    logic hund_tick_ff;
    logic tenths_wrap;
    logic hund_wrap;
    assign tenths_wrap = tenths_div_ff == 32'(TENTHS_CYCLES - 1);
    assign hund_wrap = hund_div_ff == 32'(HUND_CYCLES - 1);

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            tenths_div_ff <= `BTC_ZERO8;
            tenths_tick_ff <= 1'b0;
        end else begin
            // 0.1 s tick from the clock
            tenths_div_ff <= tenths_wrap ? `BTC_ZERO8 : tenths_div_ff + 1;
            tenths_tick_ff <= tenths_wrap;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            hund_div_ff <= `BTC_ZERO8;
            hund_tick_ff <= 1'b0;
        end else begin
            // 0.01 s tick from the clock
            hund_div_ff <= hund_wrap ? `BTC_ZERO8 : hund_div_ff + 1;
            hund_tick_ff <= hund_wrap;
        end
    end

    // accumulating timers
    btc_tmr_ctl_t tmr_ctl [2];
    logic tmr_tick [2];
    logic [31:0] tmr_val_ff [2];
    logic tmr_done_ff [2];
    assign tmr_ctl[0] = TENTHS_CTL;
    assign tmr_ctl[1] = HUND_CTL;
    assign tmr_tick[0] = tenths_tick_ff;
    assign tmr_tick[1] = hund_tick_ff;

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_tmr
            logic [31:0] stepped;
            logic [31:0] nxt_val;
            btc_bcd_step #(.DIGITS(8)) u_step (
                .value(tmr_val_ff[t]),
                .up(1'b1),
                .down(1'b0),
                .result(stepped)
            );
            always_comb begin
                nxt_val = tmr_val_ff[t];
                if (tmr_ctl[t].rst) begin
                    nxt_val = `BTC_ZERO8;
                end else if (tmr_ctl[t].en && tmr_tick[t] &&
                             tmr_val_ff[t] != `BTC_MAX8) begin
                    nxt_val = stepped;
                end
            end
            always_ff @(posedge MCLK) begin
                if (SYS_RST) begin
                    tmr_val_ff[t] <= `BTC_ZERO8;
                    tmr_done_ff[t] <= 1'b0;
                end else begin
                    tmr_val_ff[t] <= nxt_val;
                    tmr_done_ff[t] <= !tmr_ctl[t].rst &&
                                      nxt_val >= tmr_ctl[t].preset;
                end
            end
            chk_tmr_reset_clear: assert property (
                @(posedge MCLK) disable iff (SYS_RST)
                tmr_ctl[t].rst |=> tmr_val_ff[t] == `BTC_ZERO8 &&
                                   !tmr_done_ff[t])
                else $error("timer not cleared by its reset");
            chk_tmr_hold_off: assert property (
                @(posedge MCLK) disable iff (SYS_RST)
                !tmr_ctl[t].en && !tmr_ctl[t].rst
                |=> $stable(tmr_val_ff[t]))
                else $error("timer moved while disabled");
            chk_tmr_done_cmp: assert property (
                @(posedge MCLK) disable iff (SYS_RST)
                !$past(SYS_RST) && !$past(tmr_ctl[t].rst)
                |-> tmr_done_ff[t] ==
                (tmr_val_ff[t] >= $past(tmr_ctl[t].preset)))
                else $error("timer done flag disagrees with value");
        end
    endgenerate

    chk_tenths_rate: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        tenths_tick_ff |=> !tenths_tick_ff [*2])
        else $error("tenths tick came too soon");

    // counters: edge detection against last cycle's inputs
    logic up_prev_ff;
    logic udc_up_prev_ff;
    logic udc_dn_prev_ff;
    logic stage_prev_ff;
    logic up_rise;
    logic udc_up_rise;
    logic udc_dn_rise;
    logic stage_rise;
    assign up_rise = UPCNT_CTL.count && !up_prev_ff;
    assign udc_up_rise = UDC_CTL.up && !udc_up_prev_ff && !UDC_CTL.down;
    assign udc_dn_rise = UDC_CTL.down && !udc_dn_prev_ff && !UDC_CTL.up;
    assign stage_rise = STAGE_CTL.count && !stage_prev_ff;

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            up_prev_ff <= 1'b0;
            udc_up_prev_ff <= 1'b0;
            udc_dn_prev_ff <= 1'b0;
            stage_prev_ff <= 1'b0;
        end else begin
            up_prev_ff <= UPCNT_CTL.count;
            udc_up_prev_ff <= UDC_CTL.up;
            udc_dn_prev_ff <= UDC_CTL.down;
            stage_prev_ff <= STAGE_CTL.count;
        end
    end

    // up counter
    logic [15:0] up_val_ff;
    logic up_done_ff;
    logic [15:0] up_stepped;
    logic [15:0] nxt_up_val;
    btc_bcd_step #(.DIGITS(4)) u_up_step (
        .value(up_val_ff),
        .up(1'b1),
        .down(1'b0),
        .result(up_stepped)
    );
    always_comb begin
        nxt_up_val = up_val_ff;
        if (UPCNT_CTL.rst) begin
            nxt_up_val = `BTC_ZERO4;
        end else if (up_rise && up_val_ff != `BTC_MAX4) begin
            nxt_up_val = up_stepped;
        end
    end
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            up_val_ff <= `BTC_ZERO4;
            up_done_ff <= 1'b0;
        end else begin
            up_val_ff <= nxt_up_val;
            up_done_ff <= !UPCNT_CTL.rst && nxt_up_val >= UPCNT_CTL.preset;
        end
    end

    chk_up_no_level: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        !$past(SYS_RST) && $past(UPCNT_CTL.count) && !UPCNT_CTL.rst
        |=> $stable(up_val_ff))
        else $error("up counter counted on a held level");
    chk_up_saturate: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        up_val_ff == `BTC_MAX4 && !UPCNT_CTL.rst
        |=> up_val_ff == `BTC_MAX4)
        else $error("up counter left its ceiling");
    chk_up_reset_wins: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        UPCNT_CTL.rst && up_rise |=> up_val_ff == `BTC_ZERO4 && !up_done_ff)
        else $error("count beat reset on up counter");

    // up/down counter
    logic [31:0] udc_val_ff;
    logic udc_done_ff;
    logic [31:0] udc_stepped;
    logic [31:0] nxt_udc_val;
    logic udc_step_up;
    logic udc_step_dn;
    // no step past 99999999 or below zero
    assign udc_step_up = udc_up_rise && udc_val_ff != `BTC_MAX8;
    assign udc_step_dn = udc_dn_rise && udc_val_ff != `BTC_ZERO8;
    btc_bcd_step #(.DIGITS(8)) u_udc_step (
        .value(udc_val_ff),
        .up(udc_step_up),
        .down(udc_step_dn),
        .result(udc_stepped)
    );
    always_comb begin
        nxt_udc_val = udc_val_ff;
        if (UDC_CTL.rst) begin
            nxt_udc_val = `BTC_ZERO8;
        end else if (udc_step_up || udc_step_dn) begin
            nxt_udc_val = udc_stepped;
        end
    end
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            udc_val_ff <= `BTC_ZERO8;
            udc_done_ff <= 1'b0;
        end else begin
            udc_val_ff <= nxt_udc_val;
            udc_done_ff <= !UDC_CTL.rst && nxt_udc_val >= UDC_CTL.preset;
        end
    end

    chk_udc_both_high: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        UDC_CTL.up && UDC_CTL.down && !UDC_CTL.rst |=> $stable(udc_val_ff))
        else $error("up/down counted with both inputs high");

    // stage counter: only the command clears it
    logic [15:0] stage_val_ff;
    logic stage_done_ff;
    logic [15:0] stage_stepped;
    logic [15:0] nxt_stage_val;
    btc_bcd_step #(.DIGITS(4)) u_stage_step (
        .value(stage_val_ff),
        .up(1'b1),
        .down(1'b0),
        .result(stage_stepped)
    );
    always_comb begin
        nxt_stage_val = stage_val_ff;
        if (STAGE_CTL.rst) begin
            nxt_stage_val = `BTC_ZERO4;
        end else if (stage_rise && stage_val_ff != `BTC_MAX4) begin
            nxt_stage_val = stage_stepped;
        end
    end
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            stage_val_ff <= `BTC_ZERO4;
            stage_done_ff <= 1'b0;
        end else begin
            stage_val_ff <= nxt_stage_val;
            stage_done_ff <= !STAGE_CTL.rst &&
                             nxt_stage_val >= STAGE_CTL.preset;
        end
    end

    chk_stage_keeps: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        !STAGE_CTL.rst && !STAGE_CTL.count |=> $stable(stage_val_ff))
        else $error("stage counter changed without an edge");

    // registered stage word for the last slot
    logic [9:0] stage_addr_ff;
    logic [15:0] stage_word_ff;
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            stage_addr_ff <= `BTC_CNT_BASE;
            stage_word_ff <= `BTC_ZERO4;
        end else begin
            stage_addr_ff <= `BTC_CNT_BASE + {2'b00, STAGE_NUM};
            stage_word_ff <= stage_val_ff;
        end
    end

    // value memory write-back, one word per cycle in turn
    logic [2:0] slot_ff;
    logic [9:0] wr_addr;
    logic [15:0] wr_data;
    logic wr_en;
    logic [9:0] udc_base;
    assign udc_base = `BTC_CNT_BASE + {2'b00, UDC_NUM};

    always_ff @(posedge MCLK) begin
        if (SYS_RST || slot_ff == `BTC_SLOT_LAST) begin
            slot_ff <= `BTC_SLOT_FIRST;
        end else begin
            slot_ff <= slot_ff + 3'h1;
        end
    end

    always_comb begin
        wr_en = 1'b1;
        wr_addr = {2'b00, TENTHS_NUM};
        wr_data = tmr_val_ff[0][15:0];
        case (slot_ff)
            3'h0: begin
                // low word at the timer's own number
                wr_addr = {2'b00, TENTHS_NUM};
                wr_data = tmr_val_ff[0][15:0];
            end
            3'h1: begin
                // second slot only up to 376
                wr_en = TENTHS_NUM <= `BTC_TMR_LAST;
                wr_addr = {2'b00, TENTHS_NUM} + `BTC_ADDR_ONE;
                wr_data = tmr_val_ff[0][31:16];
            end
            3'h2: begin
                wr_addr = {2'b00, HUND_NUM};
                wr_data = tmr_val_ff[1][15:0];
            end
            3'h3: begin
                wr_en = HUND_NUM <= `BTC_TMR_LAST;
                wr_addr = {2'b00, HUND_NUM} + `BTC_ADDR_ONE;
                wr_data = tmr_val_ff[1][31:16];
            end
            3'h4: begin
                // counter word at number plus 1000 octal
                wr_addr = `BTC_CNT_BASE + {2'b00, UPCNT_NUM};
                wr_data = up_val_ff;
            end
            3'h5: begin
                wr_addr = udc_base;
                wr_data = udc_val_ff[15:0];
            end
            3'h6: begin
                // upper half in the next counter slot
                wr_en = UDC_NUM <= `BTC_TMR_LAST;
                wr_addr = udc_base + `BTC_ADDR_ONE;
                wr_data = udc_val_ff[31:16];
            end
            default: begin
                // stage counter word
                wr_addr = stage_addr_ff;
                wr_data = stage_word_ff;
            end
        endcase
    end

    logic [15:0] rd_data;
    logic rd_valid_ff;
    btc_value_mem u_mem (
        .clk(MCLK),
        .rst(SYS_RST),
        .we(wr_en),
        .waddr(wr_addr),
        .wdata(wr_data),
        .re(RD_REQ.en),
        .raddr(RD_REQ.addr),
        .rdata_ff(rd_data)
    );
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= RD_REQ.en;
        end
    end

    assign TENTHS_STAT = {tmr_done_ff[0], tmr_val_ff[0]};
    assign HUND_STAT = {tmr_done_ff[1], tmr_val_ff[1]};
    assign UPCNT_STAT = {up_done_ff, up_val_ff};
    assign UDC_STAT = {udc_done_ff, udc_val_ff};
    assign STAGE_STAT = {stage_done_ff, stage_val_ff};
    assign RD_RESP = {rd_valid_ff, rd_data};

    chk_read_latency: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        RD_REQ.en |=> RD_RESP.valid ##1 !RD_RESP.valid || $past(RD_REQ.en))
        else $error("read answer did not follow request");
endmodule

/* tb/btc_scan.sv */
// scan logic model driving timer and counter control inputs
// assumes the bench calls its tasks; all changes on rising MCLK
module btc_scan (
    input wire logic mclk,
    output btc_pkg::btc_tmr_ctl_t tenths_ctl,
    output btc_pkg::btc_tmr_ctl_t hund_ctl,
    output btc_pkg::btc_cnt_ctl_t upcnt_ctl,
    output btc_pkg::btc_udc_ctl_t udc_ctl,
    output btc_pkg::btc_cnt_ctl_t stage_ctl
);
    timeunit 1ns;
    timeprecision 1ns;
    import btc_pkg::*;
    initial begin
        tenths_ctl = '0;
        hund_ctl = '0;
        upcnt_ctl = '0;
        udc_ctl = '0;
        stage_ctl = '0;
    end
    // timer enable, reset and preset; 0 tenths, 1 hundredths
    task automatic tmr_set(input int sel, input logic en, input logic rst,
        input logic [31:0] p);
        @(posedge mclk);
        if (sel == 0) begin
            tenths_ctl <= '{en, rst, p};
        end else begin
            hund_ctl <= '{en, rst, p};
        end
    endtask
    // counter reset and preset; 0 up, 1 stage, 2 up/down
    task automatic cnt_set(input int sel, input logic rst,
        input logic [31:0] p);
        @(posedge mclk);
        case (sel)
            0: upcnt_ctl[16:0] <= {rst, p[15:0]};
            1: stage_ctl[16:0] <= {rst, p[15:0]};
            default: udc_ctl[32:0] <= {rst, p};
        endcase
    endtask
    // one count line; the other up/down line stays low
    task automatic drive(input int sel, input logic v);
        case (sel)
            0: upcnt_ctl.count <= v;
            1: stage_ctl.count <= v;
            2: udc_ctl.up <= v;
            default: udc_ctl.down <= v;
        endcase
    endtask
    // rises with a low cycle between them
    task automatic pulse(input int sel, input int n, input int high = 1);
        repeat (n) begin
            @(posedge mclk);
            drive(sel, 1'b1);
            repeat (high) @(posedge mclk);
            drive(sel, 1'b0);
        end
    endtask
    // count rise and reset in the same cycle
    task automatic race_rst;
        @(posedge mclk);
        upcnt_ctl.count <= 1'b1;
        upcnt_ctl.rst <= 1'b1;
        @(posedge mclk);
        upcnt_ctl.count <= 1'b0;
        upcnt_ctl.rst <= 1'b0;
    endtask
    // both up/down lines rise together, on purpose
    task automatic both_udc;
        @(posedge mclk);
        udc_ctl.up <= 1'b1;
        udc_ctl.down <= 1'b1;
        @(posedge mclk);
        udc_ctl.up <= 1'b0;
        udc_ctl.down <= 1'b0;
    endtask
endmodule

/* tb/btc_top_tb.sv */
// self-checking bench for the timer and counter block
// assumes short time-base parameters and the btc_scan model
module btc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import btc_pkg::*;
    localparam int TEN = 10;
    localparam int HUN = 4;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    // second slot of each 8-digit item left free
    logic [7:0] ten_num = 8'h06;
    logic [7:0] hun_num = 8'h0A;
    logic [7:0] up_num = 8'h02;
    logic [7:0] udc_num = 8'h05;
    logic [7:0] stg_num = 8'h07;
    btc_tmr_ctl_t ten_ctl, hun_ctl;
    btc_cnt_ctl_t up_ctl, stg_ctl;
    btc_udc_ctl_t udc_ctl;
    btc_rd_req_t rd_req = '0;
    btc_stat8_t ten_st, hun_st, udc_st;
    btc_stat4_t up_st, stg_st;
    btc_rd_resp_t rd_resp;
    int bad_count = 0;
    int compares = 0;
    always #25 MCLK = ~MCLK;
    btc_scan u_btc_scan (.mclk(MCLK), .tenths_ctl(ten_ctl),
        .hund_ctl(hun_ctl), .upcnt_ctl(up_ctl), .udc_ctl(udc_ctl),
        .stage_ctl(stg_ctl));
    btc_top #(.TENTHS_CYCLES(TEN), .HUND_CYCLES(HUN)) u_btc_top (
        .MCLK(MCLK), .SYS_RST(SYS_RST), .TENTHS_CTL(ten_ctl),
        .TENTHS_NUM(ten_num), .HUND_CTL(hun_ctl), .HUND_NUM(hun_num),
        .UPCNT_CTL(up_ctl), .UPCNT_NUM(up_num), .UDC_CTL(udc_ctl),
        .UDC_NUM(udc_num), .STAGE_CTL(stg_ctl), .STAGE_NUM(stg_num),
        .RD_REQ(rd_req), .TENTHS_STAT(ten_st), .HUND_STAT(hun_st),
        .UPCNT_STAT(up_st), .UDC_STAT(udc_st), .STAGE_STAT(stg_st),
        .RD_RESP(rd_resp));
    task automatic finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [32:0] seen, input logic [32:0] exp,
        input string msg);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time,
                msg, seen, exp);
        end
    endtask
    task automatic settle(input int n = 1);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    // done and value of one item: 0 ten, 1 hun, 2 up, 3 udc, 4 stage
    function automatic logic [32:0] st(input int sel);
        case (sel)
            0: return ten_st;
            1: return hun_st;
            2: return {up_st.done, 16'h0000, up_st.value};
            3: return udc_st;
            default: return {stg_st.done, 16'h0000, stg_st.value};
        endcase
    endfunction
    task automatic wait_val(input int sel, input logic [31:0] v,
        input int lim, output int n);
        n = 0;
        while (32'(st(sel)) !== v && n < lim) begin
            settle();
            n++;
        end
        check(32'(st(sel)), v, "value reached");
    endtask
    // memory write-back lags by up to nine cycles
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        settle(8);
        @(posedge MCLK);
        rd_req <= '{1'b1, a};
        @(posedge MCLK);
        rd_req <= '0;
        #1;
        check(33'(rd_resp.valid), 33'h1, "read valid");
        d = rd_resp.data;
    endtask
    task automatic test_tenths;
        int n;
        logic [31:0] v;
        logic [15:0] d;
        u_btc_scan.tmr_set(0, 1'b1, 1'b0, 32'h00000003);
        wait_val(0, 32'h1, 40, n);
        wait_val(0, 32'h2, 40, n);
        check(n, TEN, "tenths step");
        check(st(0) >> 32, 33'h0, "done below preset");
        wait_val(0, 32'h3, 40, n);
        check(st(0) >> 32, 33'h1, "done at preset");
        u_btc_scan.tmr_set(0, 1'b0, 1'b0, 32'h00000003);
        settle(2);
        v = 32'(st(0));
        settle(30);
        check(32'(st(0)), v, "paused value");
        rd(10'(ten_num), d);
        check(d, v[15:0], "timer low word");
        rd(10'(ten_num) + 10'h001, d);
        check(d, v[31:16], "timer high word");
        u_btc_scan.tmr_set(0, 1'b1, 1'b0, 32'h00000003);
        wait_val(0, v + 32'h1, 15, n);
        u_btc_scan.tmr_set(0, 1'b1, 1'b1, 32'h00000003);
        settle(25);
        check(st(0), 33'h0, "timer in reset");
        u_btc_scan.tmr_set(0, 1'b0, 1'b0, 32'h00000003);
    endtask
    task automatic test_hund;
        int n;
        u_btc_scan.tmr_set(1, 1'b1, 1'b0, 32'h00000010);
        wait_val(1, 32'h9, 80, n);
        wait_val(1, 32'h10, 8, n);
        check(n, HUN, "hundredths step");
        check(st(1) >> 32, 33'h1, "fast done");
        u_btc_scan.tmr_set(1, 1'b0, 1'b1, 32'h00000010);
        settle(2);
        check(st(1), 33'h0, "fast reset");
        u_btc_scan.tmr_set(1, 1'b0, 1'b0, 32'h00000010);
    endtask
    task automatic test_upcnt;
        logic [15:0] d;
        u_btc_scan.cnt_set(0, 1'b0, 32'h00000010);
        u_btc_scan.pulse(0, 1, 5);
        settle();
        check(st(2), 33'h1, "held level");
        u_btc_scan.pulse(0, 8);
        settle();
        check(st(2), 33'h9, "below preset");
        u_btc_scan.pulse(0, 1);
        settle();
        check(st(2), 33'h100000010, "carry and done");
        rd(10'h200 + 10'(up_num), d);
        check(d, 16'h0010, "counter word");
        u_btc_scan.race_rst();
        settle();
        check(st(2), 33'h0, "reset wins");
        u_btc_scan.pulse(0, 10001);
        settle();
        check(st(2), 33'h100009999, "ceiling");
        u_btc_scan.cnt_set(0, 1'b1, 32'h00000010);
        settle(2);
        check(st(2), 33'h0, "counter reset");
        u_btc_scan.cnt_set(0, 1'b0, 32'h00000010);
    endtask
    task automatic test_udc;
        logic [15:0] d;
        u_btc_scan.cnt_set(2, 1'b0, 32'h00000003);
        u_btc_scan.pulse(2, 10);
        settle();
        check(st(3), 33'h100000010, "up count");
        u_btc_scan.pulse(3, 1);
        settle();
        check(st(3), 33'h100000009, "down borrow");
        u_btc_scan.both_udc();
        settle();
        check(st(3), 33'h100000009, "both lines");
        rd(10'h200 + 10'(udc_num), d);
        check(d, 16'h0009, "udc low word");
        rd(10'h201 + 10'(udc_num), d);
        check(d, 16'h0000, "udc high word");
        u_btc_scan.cnt_set(2, 1'b1, 32'h00000003);
        settle(2);
        check(st(3), 33'h0, "udc reset");
        u_btc_scan.cnt_set(2, 1'b0, 32'h00000003);
        u_btc_scan.pulse(3, 1);
        settle();
        check(st(3), 33'h0, "floor");
    endtask
    task automatic test_stage;
        logic [15:0] d;
        u_btc_scan.cnt_set(1, 1'b0, 32'h00000002);
        u_btc_scan.pulse(1, 3);
        settle();
        check(st(4), 33'h100000003, "stage count");
        u_btc_scan.pulse(1, 1, 6);
        settle(10);
        check(st(4), 33'h100000004, "level kept");
        rd(10'h200 + 10'(stg_num), d);
        check(d, 16'h0004, "stage word");
        u_btc_scan.cnt_set(1, 1'b1, 32'h00000002);
        settle(2);
        check(st(4), 33'h0, "reset command");
        u_btc_scan.cnt_set(1, 1'b0, 32'h00000002);
    endtask
    initial begin
        repeat (2) @(posedge MCLK);
        SYS_RST <= 1'b0;
        #1;
        check(st(3), 33'h0, "in reset");
        settle();
        check(st(3), 33'h100000000, "zero preset done");
        test_tenths();
        test_hund();
        test_upcnt();
        test_udc();
        test_stage();
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge MCLK);
        bad_count++;
        finish_test();
    end
endmodule
